// [bit_link_if.sv]
// Bit-level link between the command sequencer and the pin engine
`timescale 1ns/1ps
interface bit_link_if;
  logic rx_valid;
  logic rx_bit;
  logic tx_req;
  logic tx_bit;
  logic tx_done;
  logic ack_req;
  logic ack_done;

  modport engine (
    input  tx_req,
    input  tx_bit,
    input  ack_req,
    output rx_valid,
    output rx_bit,
    output tx_done,
    output ack_done
  );

  modport ctrl (
    output tx_req,
    output tx_bit,
    output ack_req,
    input  rx_valid,
    input  rx_bit,
    input  tx_done,
    input  ack_done
  );
endinterface

// [host_pod.sv]
// Behavioural debug host pod that drives and samples the single-wire pin
`timescale 1ns/1ps
module host_pod (
  input  wire logic clk_sys,
  input  wire logic dut_out,
  input  wire logic dut_oe,
  output wire logic pin
);
  logic    host_oe   = 1'b0;
  logic    host_out  = 1'b1;
  realtime last_edge = 0;

  // Pulled-up wire: any low driver wins, a released line reads high
  assign pin = (dut_oe ? dut_out : 1'b1) & (host_oe ? host_out : 1'b1);

  task automatic host_bit(input logic b);
    last_edge = $realtime;
    host_oe <= 1'b1;
    host_out <= 1'b0;
    repeat (b ? 4 : 16) @(posedge clk_sys);
    host_out <= 1'b1;
    repeat (2) @(posedge clk_sys);
    host_oe <= 1'b0;
    repeat (b ? 18 : 6) @(posedge clk_sys);
  endtask

  // A one that rises too late for the target's glitch check, so it must be dropped
  task automatic late_bit();
    host_oe <= 1'b1;
    host_out <= 1'b0;
    repeat (8) @(posedge clk_sys);
    host_out <= 1'b1;
    repeat (2) @(posedge clk_sys);
    host_oe <= 1'b0;
    repeat (14) @(posedge clk_sys);
  endtask

  // Host starts the bit, lets go early and samples as a one's speedup pulse ends, while a zero is still driven low
  task automatic target_bit(output logic b, output logic hi);
    hi = 1'b0;
    host_oe <= 1'b1;
    host_out <= 1'b0;
    repeat (3) @(posedge clk_sys);
    host_oe <= 1'b0;
    repeat (9) begin
      @(posedge clk_sys);
      hi = hi | (dut_oe & dut_out);
    end
    #1;
    b = pin;
    repeat (12) @(posedge clk_sys);
  endtask
endmodule

// [pin_bit_engine.sv]
// Pin engine: bit-start detection, host bit sampling, target bit and handshake driving
`timescale 1ns/1ps
module pin_bit_engine
  import swd_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  input  wire logic   pin_in,
  output logic        pin_out,
  output logic        pin_oe,
  bit_link_if.engine  bl
);

  typedef struct packed {
    phase_e     phase;
    logic [4:0] cnt;
    logic [2:0] sync;
    logic       lvl;
    logic       early;
    logic       tx_val;
    logic       oe;
    logic       val;
    logic       rx_valid;
    logic       rx_bit;
    logic       tx_done;
    logic       ack_done;
  } eng_s;

  eng_s r;
  eng_s next_r;
  logic fall;
  logic stable;
  logic [4:0] hi_at;

  // Only the second and third stages are compared; the first stage feeds the second alone
  assign stable = (r.sync[1] == r.sync[2]);
  assign fall   = r.lvl && stable && !r.sync[2];
  assign hi_at  = r.tx_val ? SPEEDUP_AT : ZERO_LOW_END;

  always_comb begin
    next_r          = r;
    next_r.sync     = {r.sync[1:0], pin_in};
    next_r.rx_valid = 1'b0;
    next_r.tx_done  = 1'b0;
    next_r.ack_done = 1'b0;
    if (stable) begin
      next_r.lvl = r.sync[2];
    end
    unique case (r.phase)
      P_IDLE: begin
        next_r.oe = 1'b0;
        // Wait for the host to let go, and skip the cycle that still sees the finished request
        if (bl.ack_req && r.lvl && !r.ack_done) begin
          next_r.phase = P_ACK;
          next_r.cnt   = 5'h01;
          next_r.oe    = 1'b1;
          next_r.val   = 1'b0;
        end else if (fall) begin
          next_r.cnt   = 5'h01;
          next_r.early = 1'b0;
          if (bl.tx_req) begin
            next_r.phase  = P_TX;
            next_r.tx_val = bl.tx_bit;
            next_r.oe     = !bl.tx_bit;
            next_r.val    = 1'b0;
          end else begin
            next_r.phase = P_RX;
          end
        end
      end
      P_RX: begin
        next_r.cnt = r.cnt + 5'h01;
        if (r.lvl && r.cnt <= GLITCH_LIMIT) begin
          next_r.early = 1'b1;
        end
        if (next_r.cnt == SAMPLE_AT) begin
          // A late rise means a glitch, so the bit is dropped
          next_r.rx_valid = !(r.lvl && !r.early);
          next_r.rx_bit   = r.lvl;
          next_r.phase    = P_IDLE;
        end
      end
      P_TX: begin
        next_r.cnt = r.cnt + 5'h01;
        if (next_r.cnt == hi_at) begin
          next_r.oe  = 1'b1;
          next_r.val = 1'b1;
        end else if (next_r.cnt == 5'(hi_at + SPEEDUP_LEN)) begin
          next_r.oe      = 1'b0;
          next_r.tx_done = 1'b1;
          next_r.phase   = P_IDLE;
        end
      end
      P_ACK: begin
        next_r.cnt = r.cnt + 5'h01;
        if (next_r.cnt == ACK_LOW) begin
          next_r.val = 1'b1;
        end else if (next_r.cnt == 5'(ACK_LOW + SPEEDUP_LEN)) begin
          next_r.oe       = 1'b0;
          next_r.ack_done = 1'b1;
          next_r.phase    = P_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{phase: P_IDLE, sync: 3'h7, lvl: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign pin_out     = r.val;
  assign pin_oe      = r.oe;
  assign bl.rx_valid = r.rx_valid;
  assign bl.rx_bit   = r.rx_bit;
  assign bl.tx_done  = r.tx_done;
  assign bl.ack_done = r.ack_done;

  sequence host_bit_start;
    r.phase == P_IDLE && fall && !bl.ack_req && !bl.tx_req;
  endsequence

  sequence one_bit_start;
    r.phase == P_IDLE && fall && !bl.ack_req && bl.tx_req && bl.tx_bit;
  endsequence

  sample_at_ten_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    host_bit_start |=> (r.phase == P_RX) [*8] ##1 r.phase == P_RX ##1 r.phase == P_IDLE)
    else $error("host bit not sampled ten cycles after start");

  speedup_seven_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    one_bit_start |-> !pin_oe [*7] ##1 (pin_oe && pin_out) [*2] ##1 !pin_oe)
    else $error("speedup pulse for a one bit misplaced");

  glitch_reject_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.phase == P_RX && r.cnt == 5'h09 && r.lvl && !r.early) |=> !bl.rx_valid)
    else $error("late-rising bit was accepted");

  idle_released_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    r.phase == P_IDLE |-> !pin_oe)
    else $error("pin driven between bits");

endmodule

// [single_wire_debug_commands.sv]
// Command sequencer for the single-wire debug port: decode, bus stealing, reply
`timescale 1ns/1ps
module single_wire_debug_commands
  import swd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        debug_pin_in,
  output logic             debug_pin_out,
  output logic             debug_pin_oe,
  input  wire logic        firmware_enable,
  input  wire logic        debug_resume,
  output logic             halted_debug_unit,
  input  wire logic        bus_idle,
  output logic             cpu_freeze,
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  output logic [1:0]       mem_byte_en,
  output logic             mem_debug_map,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_done
);

  typedef struct packed {
    cmd_state_e  state;
    logic [7:0]  opcode;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] shreg;
    logic [4:0]  bitcnt;
    logic [7:0]  wait_cnt;
    logic        handshake_en;
    logic        halted;
    logic        req;
    logic        freeze;
  } ctl_s;

  ctl_s r;
  ctl_s next_r;
  logic [7:0]  rx_op;
  logic [15:0] rx_word;

  bit_link_if bl ();

  pin_bit_engine u_engine (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (debug_pin_in),
    .pin_out (debug_pin_out),
    .pin_oe  (debug_pin_oe),
    .bl      (bl)
  );

  function automatic logic is_access(input logic [7:0] op);
    return op == OP_READ_DBG_B || op == OP_READ_DBG_W || op == OP_READ_B || op == OP_READ_W ||
           op == OP_WRITE_DBG_B || op == OP_WRITE_DBG_W || op == OP_WRITE_B;
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    return op[OPB_READ];
  endfunction

  function automatic logic is_word(input logic [7:0] op);
    return op[OPB_WORD];
  endfunction

  // Byte reads return the addressed byte in its lane, the other lane zero
  function automatic logic [15:0] read_lane(input logic [7:0] op, input logic [15:0] a,
                                            input logic [15:0] d);
    if (is_word(op)) begin
      return d;
    end else if (a[0]) begin
      return {8'h00, d[7:0]};
    end else begin
      return {d[15:8], 8'h00};
    end
  endfunction

  assign rx_op   = {r.shreg[6:0], bl.rx_bit};
  assign rx_word = {r.shreg[14:0], bl.rx_bit};

  always_comb begin
    next_r = r;
    if (debug_resume) begin
      next_r.halted = 1'b0;
    end
    unique case (r.state)
      ST_CMD: begin
        if (bl.rx_valid) begin
          next_r.shreg  = rx_word;
          next_r.bitcnt = r.bitcnt + 5'h01;
          if (r.bitcnt == CMD_LAST) begin
            next_r.bitcnt = 5'h00;
            next_r.opcode = rx_op;
            if (rx_op == OP_BACKGROUND) begin
              if (firmware_enable) begin
                next_r.halted = 1'b1;
                if (r.handshake_en) begin
                  next_r.state = ST_ACK;
                end
              end
            end else if (rx_op == OP_ACK_ENABLE) begin
              next_r.handshake_en = 1'b1;
              next_r.state        = ST_ACK;
            end else if (rx_op == OP_ACK_DISABLE) begin
              next_r.handshake_en = 1'b0;
            end else if (is_access(rx_op)) begin
              // Accepted regardless of the halted state
              next_r.state = ST_ADDR;
            end
          end
        end
      end
      ST_ADDR: begin
        if (bl.rx_valid) begin
          next_r.shreg  = rx_word;
          next_r.bitcnt = r.bitcnt + 5'h01;
          if (r.bitcnt == WORD_LAST) begin
            next_r.bitcnt   = 5'h00;
            next_r.addr     = rx_word;
            next_r.wait_cnt = 8'h00;
            next_r.state    = is_read(r.opcode) ? ST_WAIT : ST_WDATA;
          end
        end
      end
      ST_WDATA: begin
        if (bl.rx_valid) begin
          next_r.shreg  = rx_word;
          next_r.bitcnt = r.bitcnt + 5'h01;
          if (r.bitcnt == WORD_LAST) begin
            next_r.bitcnt = 5'h00;
            next_r.wdata  = rx_word;
            next_r.state  = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (bus_idle) begin
          next_r.req   = 1'b1;
          next_r.state = ST_BUSY;
        end else if (r.wait_cnt == STEAL_LAST) begin
          next_r.req    = 1'b1;
          next_r.freeze = 1'b1;
          next_r.state  = ST_BUSY;
        end else begin
          next_r.wait_cnt = r.wait_cnt + 8'h01;
        end
      end
      ST_BUSY: begin
        if (mem_done) begin
          next_r.req    = 1'b0;
          next_r.freeze = 1'b0;
          if (is_read(r.opcode)) begin
            next_r.shreg  = read_lane(r.opcode, r.addr, mem_rdata);
            next_r.bitcnt = 5'h00;
            next_r.state  = ST_SEND;
          end else begin
            next_r.state = ST_CMD;
          end
        end else begin
          // Held even when the access began on an idle cycle
          next_r.freeze = 1'b1;
        end
      end
      ST_SEND: begin
        if (bl.tx_done) begin
          next_r.shreg  = {r.shreg[14:0], 1'b0};
          next_r.bitcnt = r.bitcnt + 5'h01;
          if (r.bitcnt == WORD_LAST) begin
            next_r.bitcnt = 5'h00;
            next_r.state  = ST_CMD;
          end
        end
      end
      ST_ACK: begin
        if (bl.ack_done) begin
          next_r.state = ST_CMD;
        end
      end
      default: begin
        next_r.state = ST_CMD;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{state: ST_CMD, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // The link waits on these levels; the engine times each bit from the host's edge and the handshake from the released line
  assign bl.tx_req  = (r.state == ST_SEND);
  assign bl.tx_bit  = r.shreg[15];
  assign bl.ack_req = (r.state == ST_ACK);

  assign halted_debug_unit = r.halted;
  assign cpu_freeze        = r.freeze;
  assign mem_req           = r.req;
  assign mem_we            = r.req && !is_read(r.opcode);
  // Word accesses drop the low address bit, so a stray odd address cannot split a word
  assign mem_addr          = is_word(r.opcode) ? {r.addr[15:1], 1'b0} : r.addr;
  assign mem_wdata         = r.wdata;
  assign mem_byte_en       = is_word(r.opcode) ? 2'b11 : (r.addr[0] ? 2'b01 : 2'b10);
  assign mem_debug_map     = r.req && r.opcode[OPB_DBG_MAP];

  sequence cmd_done(logic [7:0] op);
    r.state == ST_CMD && bl.rx_valid && r.bitcnt == CMD_LAST && rx_op == op;
  endsequence

  sequence wait_begins;
    r.state != ST_WAIT ##1 r.state == ST_WAIT;
  endsequence

  steal_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wait_begins |-> ##[0:128] mem_req)
    else $error("bus access not taken within 128 cycles");

  idle_no_freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.state == ST_WAIT && bus_idle) |=> mem_req && !cpu_freeze)
    else $error("idle-cycle access froze the CPU");

  multi_freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (mem_req && !mem_done) |=> mem_req && cpu_freeze)
    else $error("CPU not frozen during multi-cycle access");

  map_window_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(mem_req) |-> !mem_debug_map)
    else $error("debug space mapped outside its access");

  background_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_done(OP_BACKGROUND) and firmware_enable and !debug_resume) |=>
      halted_debug_unit && ((r.state == ST_ACK) == $past(r.handshake_en)))
    else $error("halt entry or its handshake wrong");

  ack_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_done(OP_ACK_ENABLE) |=> r.handshake_en && r.state == ST_ACK)
    else $error("handshake enable did not pulse");

  ack_disable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_done(OP_ACK_DISABLE) |=> !r.handshake_en && r.state == ST_CMD)
    else $error("handshake disable misbehaved");

  byte_lane_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.state == ST_BUSY && mem_done && is_read(r.opcode) && !is_word(r.opcode)) |=>
      (r.addr[0] ? r.shreg[15:8] == 8'h00 : r.shreg[7:0] == 8'h00))
    else $error("byte read placed in wrong lane");

  word_align_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (mem_req && is_word(r.opcode)) |-> !mem_addr[0] && mem_byte_en == 2'b11)
    else $error("word access not aligned");

  halted_free_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.state == ST_CMD && bl.rx_valid && r.bitcnt == CMD_LAST && is_access(rx_op)) |=>
      r.state == ST_ADDR)
    else $error("memory command not accepted");

endmodule

// [swd_pkg.sv]
// Constants, opcodes and state types shared by the single-wire debug command logic
package swd_pkg;

  // Bit timing, in target clock cycles measured from the perceived bit start; ACK_LOW is counted from the released line
  localparam logic [4:0] SAMPLE_AT    = 5'h0A;
  localparam logic [4:0] GLITCH_LIMIT = 5'h08;
  localparam logic [4:0] SPEEDUP_AT   = 5'h07;
  localparam logic [4:0] SPEEDUP_LEN  = 5'h02;
  localparam logic [4:0] ZERO_LOW_END = 5'h0D;
  localparam logic [4:0] ACK_LOW      = 5'h10;

  // Bus cycle stealing
  localparam int         STEAL_CYCLES = 128;
  localparam logic [7:0] STEAL_LAST   = 8'(STEAL_CYCLES - 1);

  // Field lengths on the wire, last bit index
  localparam logic [4:0] CMD_LAST  = 5'h07;
  localparam logic [4:0] WORD_LAST = 5'h0F;

  // Command opcodes
  localparam logic [7:0] OP_BACKGROUND   = 8'h90;
  localparam logic [7:0] OP_ACK_ENABLE   = 8'hD5;
  localparam logic [7:0] OP_ACK_DISABLE  = 8'hD6;
  localparam logic [7:0] OP_READ_DBG_B   = 8'hE4;
  localparam logic [7:0] OP_READ_DBG_W   = 8'hEC;
  localparam logic [7:0] OP_READ_B       = 8'hE0;
  localparam logic [7:0] OP_READ_W       = 8'hE8;
  localparam logic [7:0] OP_WRITE_DBG_B  = 8'hC4;
  localparam logic [7:0] OP_WRITE_DBG_W  = 8'hCC;
  localparam logic [7:0] OP_WRITE_B      = 8'hC0;

  // Opcode field positions
  localparam int OPB_DBG_MAP = 2;
  localparam int OPB_WORD    = 3;
  localparam int OPB_READ    = 5;

  typedef enum logic [2:0] {
    ST_CMD   = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WDATA = 3'b010,
    ST_WAIT  = 3'b011,
    ST_BUSY  = 3'b100,
    ST_SEND  = 3'b101,
    ST_ACK   = 3'b110
  } cmd_state_e;

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_RX   = 2'b01,
    P_TX   = 2'b10,
    P_ACK  = 2'b11
  } phase_e;

endpackage

// [test_single_wire_debug_commands.sv]
// Self-checking bench for the single-wire debug command sequencer
`timescale 1ns/1ps
module test_single_wire_debug_commands;
  import swd_pkg::*;
  logic        clk_sys;
  logic        rst_n;
  wire logic   pin;
  logic        dut_out;
  logic        dut_oe;
  logic        firmware_enable;
  logic        debug_resume;
  logic        halted;
  logic        bus_idle;
  logic        cpu_freeze;
  logic        mem_req;
  logic        mem_we;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [1:0]  mem_byte_en;
  logic        mem_debug_map;
  logic [15:0] mem_rdata;
  logic        mem_done;
  logic [7:0]  mem [2][65536];
  logic [7:0]  ref_m [2][65536];
  int          bad_count = 0;
  int          checked   = 0;
  int          seed      = 10256;
  int          idle_mode = 0;
  int          lat       = 0;
  int          age       = 0;
  int          acc_cnt   = 0;
  int          frz_cnt   = 0;
  int          frz0      = 0;
  logic        req_frz   = 1'b0;
  realtime     req_t     = 0;
  logic [15:0] exp_addr;
  logic [1:0]  exp_be;
  logic        exp_we;
  logic        exp_map;

  single_wire_debug_commands u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .debug_pin_in(pin), .debug_pin_out(dut_out),
    .debug_pin_oe(dut_oe), .firmware_enable(firmware_enable), .debug_resume(debug_resume),
    .halted_debug_unit(halted), .bus_idle(bus_idle), .cpu_freeze(cpu_freeze),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_byte_en(mem_byte_en), .mem_debug_map(mem_debug_map), .mem_rdata(mem_rdata),
    .mem_done(mem_done)
  );
  host_pod u_host (.clk_sys(clk_sys), .dut_out(dut_out), .dut_oe(dut_oe), .pin(pin));

  // Memory answers combinationally so a zero-latency access completes in its first cycle
  assign mem_done  = (mem_req === 1'b1) && (age >= lat);
  assign mem_rdata = {mem[mem_debug_map][{mem_addr[15:1], 1'b0}], mem[mem_debug_map][{mem_addr[15:1], 1'b1}]};

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0, got}, {15'h0, exp});
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    bus_idle <= (idle_mode == 1) || (idle_mode == 0 && ($random(seed) & 1));
    if (cpu_freeze === 1'b1) frz_cnt <= frz_cnt + 1;
    if (mem_req === 1'b1 && age == 0) begin
      req_t <= $realtime;
      req_frz <= cpu_freeze;
    end
    if (mem_done) begin
      cmp16(mem_addr, exp_addr);
      cmp16({14'h0, mem_byte_en}, {14'h0, exp_be});
      cmp1(mem_we, exp_we);
      cmp1(mem_debug_map, exp_map);
      if (age > 0) cmp1(cpu_freeze, 1'b1);
      if (mem_we && mem_byte_en[1]) mem[mem_debug_map][{mem_addr[15:1], 1'b0}] <= mem_wdata[15:8];
      if (mem_we && mem_byte_en[0]) mem[mem_debug_map][{mem_addr[15:1], 1'b1}] <= mem_wdata[7:0];
      acc_cnt <= acc_cnt + 1;
      age <= 0;
    end else if (mem_req === 1'b1) age <= age + 1;
    else cmp1(mem_debug_map, 1'b0);
  end

  task automatic send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) u_host.host_bit(v[i]);
  endtask

  // Counts pulse ends, so a doubled handshake is caught as well as a missing one
  task automatic hs_check(input logic want);
    int   ends;
    logic low;
    logic was;
    ends = 0;
    was = 1'b0;
    repeat (80) begin
      @(posedge clk_sys);
      low = (dut_oe === 1'b1 && dut_out === 1'b0);
      if (was && !low) ends++;
      was = low;
    end
    cmp1(ends == 1, want);
  endtask

  task automatic access(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
    logic [15:0] got;
    logic [15:0] want;
    logic        s;
    logic        hi;
    int          n;
    int          k;
    s = op[OPB_DBG_MAP];
    exp_addr = op[OPB_WORD] ? {a[15:1], 1'b0} : a;
    exp_be = op[OPB_WORD] ? 2'b11 : (a[0] ? 2'b01 : 2'b10);
    exp_we = !op[OPB_READ];
    exp_map = s;
    want = op[OPB_WORD] ? {ref_m[s][exp_addr], ref_m[s][exp_addr | 16'h1]} :
           (a[0] ? {8'h00, ref_m[s][a]} : {ref_m[s][a], 8'h00});
    if (exp_we && exp_be[1]) ref_m[s][exp_addr] = d[15:8];
    if (exp_we && exp_be[0]) ref_m[s][exp_addr | 16'h1] = d[7:0];
    n = acc_cnt + 1;
    send(16'(op), 8);
    send(a, 16);
    if (exp_we) send(d, 16);
    for (k = 0; k < 400 && acc_cnt < n; k++) @(posedge clk_sys);
    if (acc_cnt < n) begin
      bad_count++;
      final_report();
    end
    if (!exp_we) begin
      for (int i = 15; i >= 0; i--) begin
        u_host.target_bit(got[i], hi);
        cmp1(hi, got[i]);
      end
      cmp16(got, want);
    end
  endtask

  task automatic run_mem(input int n);
    logic [7:0]  wop [3] = '{OP_WRITE_DBG_B, OP_WRITE_DBG_W, OP_WRITE_B};
    logic [7:0]  rop [3] = '{OP_READ_DBG_B, OP_READ_DBG_W, OP_READ_B};
    logic [15:0] a;
    int          k;
    for (int i = 0; i < n; i++) begin
      k = i % 3;
      a = 16'($random(seed));
      if (k == 1) a[0] = 1'b0;
      lat = $random(seed) & 3;
      access(wop[k], a, 16'($random(seed)));
      access(rop[k], a, 16'h0);
      access(wop[k][OPB_DBG_MAP] ? OP_READ_W : OP_READ_DBG_W, {a[15:1], 1'b0}, 16'h0);
    end
  endtask

  initial begin
    #500us;
    bad_count++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    firmware_enable = 1'b0;
    debug_resume = 1'b0;
    // Distinct contents per space so a wrong mapping shows up in read data
    for (int i = 0; i < 65536; i++) begin
      mem[0][i] = 8'(i) ^ 8'h3C;
      mem[1][i] = 8'(i >> 8) ^ 8'hA5;
      ref_m[0][i] = mem[0][i];
      ref_m[1][i] = mem[1][i];
    end
    repeat (10) @(posedge clk_sys);
    cmp1(dut_oe, 1'b0);
    cmp1(halted, 1'b0);
    cmp1(mem_req, 1'b0);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    send(16'(OP_ACK_DISABLE), 8);
    hs_check(1'b0);
    u_host.late_bit();
    send(16'(OP_ACK_ENABLE), 8);
    hs_check(1'b1);
    send(16'(OP_BACKGROUND), 8);
    hs_check(1'b0);
    cmp1(halted, 1'b0);
    firmware_enable <= 1'b1;
    send(16'(OP_BACKGROUND), 8);
    hs_check(1'b1);
    cmp1(halted, 1'b1);
    run_mem(6);
    debug_resume <= 1'b1;
    @(posedge clk_sys);
    debug_resume <= 1'b0;
    @(posedge clk_sys);
    cmp1(halted, 1'b0);
    run_mem(6);
    idle_mode = 2;
    lat = 1;
    access(OP_READ_B, 16'($random(seed)), 16'h0);
    cmp1((req_t - u_host.last_edge) / 5.0 >= 130.0 && (req_t - u_host.last_edge) / 5.0 <= 150.0, 1'b1);
    cmp1(req_frz, 1'b1);
    idle_mode = 1;
    lat = 0;
    frz0 = frz_cnt;
    access(OP_READ_DBG_B, 16'($random(seed)), 16'h0);
    cmp1(frz_cnt == frz0, 1'b1);
    final_report();
  end
endmodule
